// File: hw/charger_setpoint_defs.svh
// Operation
// - Charge-current word is 16 bits; only bits 12..7 drive the DAC code.
// - Charge-current LSB is 1 mA; DAC bits weigh 128 mA up to 4096 mA.
// - Charge-current requests above range saturate at 8.064 A, all-ones code.
// - Power-on reset clears the charge-current setpoint to zero.
// - Charging waits for both setpoints written; zero charge current stops it.
// - Register code 0x14 selects the charge-current setpoint for word writes.
// - Word read of the charge-current setpoint returns the stored word.
// - Battery under 2.5 V forces 128 mA; setpoint kept, back above 2.7 V.
// - Register code 0x3F selects the input-current limit for word writes.
// - Word read of the input-current limit returns the stored word.
// - Input-limit DAC uses bits 12..7 only, weights 256 mA to 8192 mA.
// - Input-limit word counts in 2 mA units.
// - Input-limit requests above 11.004 A saturate at 11.004 A; the code caps at code 0x2B, 11.008 A.
// - Input-limit requests below 256 mA give a zero limit.
// - Power-on reset loads the input limit with its 256 mA default.
// - Charging ends after 175 s without a setpoint write.
// - Charging ends when the bus clock stays low over 25 ms.
// - After a timeout charging stays off until a setpoint is written again.
// - Enable needs charge current above 0x007F and voltage above 0x000F.
// - Words travel low byte first on the bus, both directions.
// - Device answers only slave address 0001001.
`ifndef CHARGER_SETPOINT_DEFS_SVH
`define CHARGER_SETPOINT_DEFS_SVH

`define REG_CHARGE_CURRENT   8'h14
`define REG_CHARGE_VOLTAGE   8'h15
`define REG_INPUT_LIMIT      8'h3f

`define CHARGE_CURRENT_RST   16'h0000
`define CHARGE_VOLTAGE_RST   16'h0000
`define INPUT_LIMIT_RST      16'h0080

`define DAC_LSB_POS          7
`define DAC_MSB_POS          12
`define CC_MIN_VALID         16'h007f
`define CV_MIN_VALID         16'h000f
`define CC_DAC_MAX           6'h3f
`define CC_FOLDBACK_CODE     6'h01
`define IN_DAC_MAX           6'h2b

`define CORE_CLK_HZ          250000000
`define WR_TIMEOUT_S         175
`define SCL_LOW_MS           25
`define WR_TIMEOUT_CYC       (64'(`WR_TIMEOUT_S) * 64'(`CORE_CLK_HZ))
`define SCL_LOW_CYC          ((64'(`SCL_LOW_MS) * 64'(`CORE_CLK_HZ) + 64'h3e7) / 64'h3e8)
`define TIMER_W              36

`endif

// File: hw/charger_setpoint_pkg.sv
package charger_setpoint_pkg;

  typedef logic [15:0] reg_word_t;
  typedef logic [7:0]  reg_code_t;
  typedef logic [5:0]  dac_code_t;

  typedef enum logic [1:0]
  {
    LK_IDLE = 2'b01,
    LK_WAIT = 2'b10
  } lk_state_t;

endpackage

// File: hw/timer_if.sv
`timescale 1ns/1ps
interface timer_if;
  logic restart;
  logic expired;

  modport timer
  (
    input  restart,
    output expired
  );

  modport owner
  (
    output restart,
    input  expired
  );
endinterface

// File: hw/setpoint_watchdog.sv
`timescale 1ns/1ps
`include "charger_setpoint_defs.svh"
module setpoint_watchdog
  import charger_setpoint_pkg::*;
#(
  parameter logic [`TIMER_W-1:0] LIMIT = `TIMER_W'(`SCL_LOW_CYC)
)
(
  input  wire logic core_clk_i, // Core clock
  input  wire logic rst_i,      // Async reset, active high
  timer_if.timer    tif         // Restart in, expiry pulse out
);

  logic [`TIMER_W-1:0] cnt_q;
  logic                expired_q;
  wire                 at_edge = (cnt_q == LIMIT - `TIMER_W'(1));

  // Count saturates so one expiry gives one pulse
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_q     <= '0;
      expired_q <= 1'b0;
    end
    else
    begin
      expired_q <= !tif.restart && at_edge;
      if (tif.restart)
        cnt_q <= '0;
      else if (cnt_q != LIMIT)
        cnt_q <= cnt_q + `TIMER_W'(1);
    end
  end

  assign tif.expired = expired_q;

endmodule

// File: hw/charger_setpoint_regs.sv
`timescale 1ns/1ps
`include "charger_setpoint_defs.svh"
module charger_setpoint_regs
  import charger_setpoint_pkg::*;
#(
  parameter logic [`TIMER_W-1:0] WR_TIMEOUT_CYC = `TIMER_W'(`WR_TIMEOUT_CYC),
  parameter logic [`TIMER_W-1:0] SCL_LOW_CYC    = `TIMER_W'(`SCL_LOW_CYC)
)
(
  input  wire logic  core_clk_i,    // Core clock, 250 MHz
  input  wire logic  rst_i,         // Power-on reset, async, active high
  input  wire logic  link_clk_i,    // Clock of the bus slave engine
  input  wire logic  lk_wr_i,       // Completed write-word, one pulse
  input  wire logic  lk_rd_i,       // Read-word register fetch, one pulse
  input  reg_code_t  lk_code_i,     // Register code of the request
  input  reg_word_t  lk_wdata_i,    // Assembled word, low byte first on bus
  output reg_word_t  lk_rdata_o,    // Word returned for a read
  output logic       lk_rvalid_o,   // Read word valid, one pulse
  output logic       lk_busy_o,     // Request in flight, new ones ignored
  input  wire logic  scl_i,         // Bus clock pin level
  input  wire logic  batt_low_i,    // Battery below 2.5 V
  input  wire logic  batt_ok_i,     // Battery above 2.7 V
  output dac_code_t  charge_current_dac_code_o, // Charge DAC code
  output dac_code_t  input_limit_dac_code_o,    // Input limit DAC code
  output logic       charge_en_o,   // Charger enabled
  output logic       timeout_o      // Watchdog has ended charging
);

  // ---------------- Link domain ----------------
  lk_state_t lk_state_q;
  lk_state_t lk_state_d;
  logic      lk_req_tgl_q;
  logic      lk_is_wr_q;
  reg_code_t lk_code_q;
  reg_word_t lk_wdata_q;
  logic      lk_ack_s1_q;
  logic      lk_ack_s2_q;
  reg_word_t lk_rdata_q;
  logic      lk_rvalid_q;

  // Core-domain signals read across by the link side
  logic      ack_tgl_q;
  reg_word_t rd_word_q;

  wire lk_new_req = (lk_state_q == LK_IDLE) && (lk_wr_i || lk_rd_i);
  wire lk_acked   = (lk_state_q == LK_WAIT) && (lk_ack_s2_q == lk_req_tgl_q);

  always_comb
  begin
    lk_state_d = lk_state_q;
    case (lk_state_q)
      LK_IDLE:
        if (lk_new_req)
          lk_state_d = LK_WAIT;
      LK_WAIT:
        if (lk_acked)
          lk_state_d = LK_IDLE;
      default:
        lk_state_d = LK_IDLE;
    endcase
  end

  always_ff @(posedge link_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lk_state_q <= LK_IDLE;
    end
    else
    begin
      lk_state_q <= lk_state_d;
    end
  end

  // engine pairs bytes, filters address
  // Request held stable until the core side acknowledges it
  always_ff @(posedge link_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lk_req_tgl_q <= 1'b0;
      lk_is_wr_q   <= 1'b0;
      lk_code_q    <= 8'h00;
      lk_wdata_q   <= 16'h0000;
    end
    else if (lk_new_req)
    begin
      lk_req_tgl_q <= ~lk_req_tgl_q;
      lk_is_wr_q   <= lk_wr_i;
      lk_code_q    <= lk_code_i;
      lk_wdata_q   <= lk_wdata_i;
    end
  end

  always_ff @(posedge link_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lk_ack_s1_q <= 1'b0;
      lk_ack_s2_q <= 1'b0;
    end
    else
    begin
      lk_ack_s1_q <= ack_tgl_q;
      lk_ack_s2_q <= lk_ack_s1_q;
    end
  end

  // Read word settled two link edges before the ack is seen
  always_ff @(posedge link_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lk_rdata_q  <= 16'h0000;
      lk_rvalid_q <= 1'b0;
    end
    else
    begin
      lk_rvalid_q <= lk_acked && !lk_is_wr_q;
      if (lk_acked && !lk_is_wr_q)
        lk_rdata_q <= rd_word_q;
    end
  end

  assign lk_rdata_o  = lk_rdata_q;
  assign lk_rvalid_o = lk_rvalid_q;
  assign lk_busy_o   = lk_state_q[1];

  // ---------------- Core domain ----------------
  logic req_s1_q;
  logic req_s2_q;
  logic req_s3_q;
  logic scl_s1_q;
  logic scl_s2_q;
  logic low_s1_q;
  logic low_s2_q;
  logic ok_s1_q;
  logic ok_s2_q;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      low_s1_q <= 1'b0;
      low_s2_q <= 1'b0;
      ok_s1_q  <= 1'b0;
      ok_s2_q  <= 1'b0;
    end
    else
    begin
      req_s1_q <= lk_req_tgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      scl_s1_q <= scl_i;
      scl_s2_q <= scl_s1_q;
      low_s1_q <= batt_low_i;
      low_s2_q <= low_s1_q;
      ok_s1_q  <= batt_ok_i;
      ok_s2_q  <= ok_s1_q;
    end
  end

  // Link holding flops are stable here: the toggle waits two stages
  wire req_evt = req_s2_q ^ req_s3_q;
  wire wr_evt  = req_evt && lk_is_wr_q;
  wire rd_evt  = req_evt && !lk_is_wr_q;

  wire sel_cc = (lk_code_q == `REG_CHARGE_CURRENT);
  wire sel_cv = (lk_code_q == `REG_CHARGE_VOLTAGE);
  wire sel_il = (lk_code_q == `REG_INPUT_LIMIT);

  wire wr_cc = wr_evt && sel_cc;
  wire wr_cv = wr_evt && sel_cv;
  wire wr_il = wr_evt && sel_il;

  reg_word_t cc_q;
  reg_word_t cv_q;
  reg_word_t il_q;

  // reset values; update on completed write
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cc_q <= `CHARGE_CURRENT_RST;
      cv_q <= `CHARGE_VOLTAGE_RST;
      il_q <= `INPUT_LIMIT_RST;
    end
    else
    begin
      if (wr_cc)
        cc_q <= lk_wdata_q;
      if (wr_cv)
        cv_q <= lk_wdata_q;
      if (wr_il)
        il_q <= lk_wdata_q;
    end
  end

  wire reg_word_t rd_sel = sel_cc ? cc_q :
                           sel_cv ? cv_q :
                           sel_il ? il_q : 16'h0000;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_word_q <= 16'h0000;
      ack_tgl_q <= 1'b0;
    end
    else
    begin
      if (rd_evt)
        rd_word_q <= rd_sel;
      if (req_evt)
        ack_tgl_q <= ~ack_tgl_q;
    end
  end

  // ---------------- Watchdogs ----------------
  timer_if wr_tif();
  timer_if scl_tif();

  // restart on setpoint write or clock high
  assign wr_tif.restart  = wr_cc || wr_cv;
  assign scl_tif.restart = scl_s2_q;

  setpoint_watchdog #(.LIMIT(WR_TIMEOUT_CYC)) u_wr_wdog
  (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .tif        (wr_tif.timer)
  );

  setpoint_watchdog #(.LIMIT(SCL_LOW_CYC)) u_scl_wdog
  (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .tif        (scl_tif.timer)
  );

  logic timeout_q;

  // sticky until a setpoint write; expiry wins a tie
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      timeout_q <= 1'b0;
    else if (wr_tif.expired || scl_tif.expired)
      timeout_q <= 1'b1;
    else if (wr_cc || wr_cv)
      timeout_q <= 1'b0;
  end

  // ---------------- Foldback ----------------
  logic foldback_q;

  // hysteresis between the two battery thresholds
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      foldback_q <= 1'b0;
    else if (low_s2_q)
      foldback_q <= 1'b1;
    else if (ok_s2_q)
      foldback_q <= 1'b0;
  end

  // ---------------- Decode to DAC codes ----------------
  // six used bits, 128 mA per step
  wire dac_code_t cc_raw  = cc_q[`DAC_MSB_POS:`DAC_LSB_POS];
  // bits above 12 mean above 8.064 A
  wire            cc_over = |cc_q[15:`DAC_MSB_POS+1];
  wire dac_code_t cc_sat  = cc_over ? `CC_DAC_MAX : cc_raw;
  // stored setpoint untouched while folded back
  wire dac_code_t cc_eff  = foldback_q ? `CC_FOLDBACK_CODE : cc_sat;

  // bits 12..7, 256 mA per step of 2 mA units
  wire dac_code_t il_raw  = il_q[`DAC_MSB_POS:`DAC_LSB_POS];
  // cap near 11.004 A; DAC has no exact step there
  wire            il_over = (|il_q[15:`DAC_MSB_POS+1]) || (il_raw > `IN_DAC_MAX);
  // under 256 mA the used bits are already zero
  wire dac_code_t il_eff  = il_over ? `IN_DAC_MAX : il_raw;

  // both setpoints valid; zero current fails the test
  wire setpoints_ok = (cc_q > `CC_MIN_VALID) && (cv_q > `CV_MIN_VALID);
  wire enable_d     = setpoints_ok && !timeout_q;

  logic      charge_en_q;
  dac_code_t cc_dac_q;
  dac_code_t il_dac_q;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      charge_en_q <= 1'b0;
      cc_dac_q    <= 6'h00;
      il_dac_q    <= 6'h00;
    end
    else
    begin
      charge_en_q <= enable_d;
      cc_dac_q    <= enable_d ? cc_eff : 6'h00;
      il_dac_q    <= il_eff;
    end
  end

  assign charge_en_o               = charge_en_q;
  assign charge_current_dac_code_o = cc_dac_q;
  assign input_limit_dac_code_o    = il_dac_q;
  assign timeout_o                 = timeout_q;

endmodule

// File: sim/charger_setpoint_regs_monitor.sv
`timescale 1ns/1ps
module charger_setpoint_regs_monitor
  import charger_setpoint_pkg::*;
#(
  parameter logic [35:0] WR_TIMEOUT_CYC = 36'h5dc,
  parameter logic [35:0] SCL_LOW_CYC    = 36'h032
)
(
  input wire logic      core_clk_i,                // Core clock
  input wire logic      rst_i,                     // Reset
  input wire logic      link_clk_i,                // Link clock
  input wire logic      lk_wr_i,                   // Write request
  input wire logic      lk_rd_i,                   // Read request
  input wire logic      lk_busy_o,                 // Busy
  input wire logic      lk_rvalid_o,               // Read valid
  input wire logic      batt_low_i,                // Low battery
  input wire dac_code_t charge_current_dac_code_o, // Charge code
  input wire dac_code_t input_limit_dac_code_o,    // Input code
  input wire logic      charge_en_o,               // Enable
  input wire logic      timeout_o                  // Timeout
);
  sequence busy_end_s;
    !lk_busy_o;
  endsequence

  // Long enough for the two-flop sync plus the foldback register
  sequence low_held_s;
    batt_low_i [*6];
  endsequence

  chk_take_busy: assert property (@(posedge link_clk_i) disable iff (rst_i)
    (lk_wr_i || lk_rd_i) && !lk_busy_o |=> lk_busy_o) else $error("request not taken");
  chk_busy_bound: assert property (@(posedge link_clk_i) disable iff (rst_i)
    $rose(lk_busy_o) |-> ##[1:12] busy_end_s) else $error("busy too long");
  chk_read_ack: assert property (@(posedge link_clk_i) disable iff (rst_i)
    lk_rvalid_o |-> $past(lk_busy_o) && !lk_busy_o) else $error("read answer misplaced");
  chk_rvalid_pulse: assert property (@(posedge link_clk_i) disable iff (rst_i)
    lk_rvalid_o |=> !lk_rvalid_o) else $error("read valid too long");
  chk_input_reset: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $fell(rst_i) |-> ##[0:2] input_limit_dac_code_o == 6'h01) else $error("input default");
  chk_en_dac: assert property (@(posedge core_clk_i) disable iff (rst_i)
    charge_en_o |-> charge_current_dac_code_o != 6'h00) else $error("enabled at zero code");
  chk_timeout_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
    timeout_o && $past(timeout_o) |-> !charge_en_o) else $error("enabled after timeout");
  chk_fold_code: assert property (@(posedge core_clk_i) disable iff (rst_i)
    low_held_s ##0 charge_en_o |-> charge_current_dac_code_o == 6'h01) else $error("foldback");
endmodule

// File: sim/link_host_model.sv
`timescale 1ns/1ps
module link_host_model
  import charger_setpoint_pkg::*;
(
  input  wire logic      link_clk_i, // Link clock
  input  wire logic      busy_i,     // Device busy
  input  wire logic      rvalid_i,   // Read strobe
  input  wire reg_word_t rdata_i,    // Read word
  output logic           wr_o,       // Write request
  output logic           rd_o,       // Read request
  output reg_code_t      code_o,     // Register code
  output reg_word_t      wdata_o     // Write word
);
  initial
  begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    code_o = 8'h00;
    wdata_o = 16'h0000;
  end

  task automatic req(input logic w, input reg_code_t c, input reg_word_t d, output reg_word_t r);
    int n;
    r = 'x;
    @(negedge link_clk_i);
    wr_o = w;
    rd_o = !w;
    code_o = c;
    // whole word, low byte paired first
    wdata_o = d;
    @(negedge link_clk_i);
    wr_o = 1'b0;
    rd_o = 1'b0;
    // Released lines flip so a late sample cannot look right
    code_o = ~c;
    wdata_o = ~d;
    // Sample between edges so busy and the read strobe are settled
    for (n = 0; n < 20; n++)
    begin
      @(negedge link_clk_i);
      if (rvalid_i)
        r = rdata_i;
      if (!busy_i)
        break;
    end
  endtask
endmodule

// File: sim/charger_setpoint_regs_tb_top.sv
`timescale 1ns/1ps
module charger_setpoint_regs_tb_top;
  import charger_setpoint_pkg::*;

  typedef struct {reg_code_t code; reg_word_t data; dac_code_t cc; dac_code_t il; logic en;} row_t;

  logic      core_clk_i, link_clk_i, rst_i, scl_i, batt_low_i, batt_ok_i;
  logic      lk_wr_i, lk_rd_i, lk_rvalid_o, lk_busy_o, charge_en_o, timeout_o;
  reg_code_t lk_code_i;
  reg_word_t lk_wdata_i, lk_rdata_o, q;
  dac_code_t charge_current_dac_code_o, input_limit_dac_code_o;
  int        err_total = 0;
  int        comparisons = 0;
  row_t      rows [12] = '{
    '{8'h15, 16'h0010, 6'h00, 6'h01, 1'b0}, '{8'h14, 16'h0080, 6'h01, 6'h01, 1'b1},
    '{8'h14, 16'h007f, 6'h00, 6'h01, 1'b0}, '{8'h14, 16'h1f80, 6'h3f, 6'h01, 1'b1},
    '{8'h14, 16'he0ff, 6'h3f, 6'h01, 1'b1}, '{8'h14, 16'h0d7f, 6'h1a, 6'h01, 1'b1},
    '{8'h3f, 16'h1580, 6'h1a, 6'h2b, 1'b1}, '{8'h3f, 16'h1600, 6'h1a, 6'h2b, 1'b1},
    '{8'h3f, 16'h007f, 6'h1a, 6'h00, 1'b1}, '{8'h3f, 16'h2080, 6'h1a, 6'h2b, 1'b1},
    '{8'h14, 16'h0000, 6'h00, 6'h2b, 1'b0}, '{8'h16, 16'hffff, 6'h00, 6'h2b, 1'b0}};

  charger_setpoint_regs #(.WR_TIMEOUT_CYC(36'h5dc), .SCL_LOW_CYC(36'h032)) charger_setpoint_regs_i
    (.core_clk_i, .rst_i, .link_clk_i, .lk_wr_i, .lk_rd_i, .lk_code_i, .lk_wdata_i, .lk_rdata_o,
     .lk_rvalid_o, .lk_busy_o, .scl_i, .batt_low_i, .batt_ok_i, .charge_current_dac_code_o,
     .input_limit_dac_code_o, .charge_en_o, .timeout_o);

  link_host_model link_host_model_i (.link_clk_i, .busy_i(lk_busy_o), .rvalid_i(lk_rvalid_o),
    .rdata_i(lk_rdata_o), .wr_o(lk_wr_i), .rd_o(lk_rd_i), .code_o(lk_code_i), .wdata_o(lk_wdata_i));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wait_core(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  task automatic wr(input reg_code_t c, input reg_word_t d);
    link_host_model_i.req(1'b1, c, d, q);
    wait_core(4);
  endtask

  task automatic rd(input reg_code_t c);
    link_host_model_i.req(1'b0, c, 16'h0000, q);
  endtask

  // Held over three slow-clock edges so both domains see it
  task automatic do_reset;
    rst_i = 1'b1;
    repeat (3) @(posedge link_clk_i);
    @(negedge core_clk_i);
    rst_i = 1'b0;
  endtask

  initial
  begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  initial
  begin
    link_clk_i = 1'b0;
    #7;
    forever #24 link_clk_i = ~link_clk_i;
  end

  initial
  begin
    #200000;
    err_total++;
    finish_test();
  end

  initial
  begin
    scl_i = 1'b1;
    batt_low_i = 1'b0;
    batt_ok_i = 1'b1;
    do_reset();
    foreach (rows[i])
    begin
      wr(rows[i].code, rows[i].data);
      rd(rows[i].code);
      check(q, (rows[i].code inside {8'h14, 8'h15, 8'h3f}) ? rows[i].data : 16'h0000);
      check(16'(charge_current_dac_code_o), 16'(rows[i].cc));
      check(16'(input_limit_dac_code_o), 16'(rows[i].il));
      check(16'(charge_en_o), 16'(rows[i].en));
    end
    wr(8'h14, 16'h1f80);
    batt_ok_i = 1'b0;
    batt_low_i = 1'b1;
    wait_core(8);
    check(16'(charge_current_dac_code_o), 16'h0001);
    batt_low_i = 1'b0;
    wait_core(8);
    check(16'(charge_current_dac_code_o), 16'h0001);
    batt_ok_i = 1'b1;
    wait_core(8);
    check(16'(charge_current_dac_code_o), 16'h003f);
    do_reset();
    rd(8'h14);
    check(q, 16'h0000);
    rd(8'h3f);
    check(q, 16'h0080);
    check(16'(input_limit_dac_code_o), 16'h0001);
    check(16'(charge_en_o), 16'h0000);
    wr(8'h15, 16'h0010);
    wr(8'h14, 16'h0080);
    check(16'(charge_en_o), 16'h0001);
    wait_core(1300);
    wr(8'h14, 16'h0080);
    wait_core(1300);
    check(16'(timeout_o), 16'h0000);
    wait_core(300);
    check(16'(timeout_o), 16'h0001);
    check(16'(charge_en_o), 16'h0000);
    wr(8'h15, 16'h0010);
    check(16'(charge_en_o), 16'h0001);
    scl_i = 1'b0;
    wait_core(40);
    scl_i = 1'b1;
    wait_core(4);
    check(16'(timeout_o), 16'h0000);
    scl_i = 1'b0;
    wait_core(60);
    check(16'(charge_en_o), 16'h0000);
    scl_i = 1'b1;
    wr(8'h14, 16'h0080);
    check(16'(timeout_o), 16'h0000);
    finish_test();
  end
endmodule

bind charger_setpoint_regs charger_setpoint_regs_monitor #(.WR_TIMEOUT_CYC(WR_TIMEOUT_CYC),
  .SCL_LOW_CYC(SCL_LOW_CYC)) charger_setpoint_regs_monitor_i (.core_clk_i, .rst_i, .link_clk_i,
  .lk_wr_i, .lk_rd_i, .lk_busy_o, .lk_rvalid_o, .batt_low_i, .charge_current_dac_code_o,
  .input_limit_dac_code_o, .charge_en_o, .timeout_o);
